//--- design/link_regs_defines.svh
// register offsets, field layouts, reset values and timing counts of the link register pair
`ifndef LINK_REGS_DEFINES_SVH
`define LINK_REGS_DEFINES_SVH

// byte addresses of the two registers
`define LCAP_OFFSET 12'h04c
`define LCTL_OFFSET 12'h050

// link capabilities field positions
`define SPD_MSB 3
`define WID_MSB 9
`define WID_LSB 4
`define LPS_MSB 11
`define LPS_LSB 10
`define L0S_MSB 14
`define L0S_LSB 12
`define L1_MSB 17
`define L1_LSB 15
`define PORT_LSB 24

// link capabilities constant codes and reset values
`define MAX_SPEED_CODE 4'h1
`define WIDTH_RST 6'h08
`define WIDTH_X1 6'h01
`define WIDTH_X2 6'h02
`define WIDTH_X4 6'h04
`define WIDTH_X8 6'h08
`define LOW_POWER_CODE 2'h3
`define L0S_SEPARATE 3'h5
`define L0S_COMMON 3'h3
`define L1_RST 3'h2

// link control field positions and reset values
`define ASPM_MSB 1
`define RCB_BIT 3
`define LINK_DISABLE_BIT 4
`define LINK_RETRAIN_BIT 5
`define COMMON_CLOCK_CFG_BIT 6
`define EXTENDED_SYNC_BIT 7
`define ASPM_RST 2'h0

// fast training sequence counts per L0s exit
`define FTS_EXT_CNT 13'h1000
`define FTS_STD_CNT 13'h0080

`endif

//--- design/link_regs_pkg.sv
// shared types of the link register block
`default_nettype none
package link_regs_pkg;
  typedef logic [11:0] addr_t;
  typedef logic [31:0] word_t;
  typedef logic [3:0] strb_t;
  typedef enum logic [1:0] {FTS_IDLE, FTS_SEND, SKP_SEND} fts_state_e;
endpackage
`default_nettype wire

//--- design/link_bus_if.sv
// register access carrier between the bus port and the register bank
`default_nettype none
interface link_bus_if;
  import link_regs_pkg::*;
  logic wrStb;
  addr_t addr;
  word_t wdata;
  strb_t strb;
  word_t rdData;
  logic hit;
  modport port (output wrStb, output addr, output wdata, output strb, input rdData, input hit);
  modport regs (input wrStb, input addr, input wdata, input strb, output rdData, output hit);
endinterface
`default_nettype wire

//--- design/link_apb_port.sv
// apb slave front end with one zero-wait access phase
`include "link_regs_defines.svh"
`default_nettype none
module link_apb_port
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire link_regs_pkg::addr_t paddr,
  input wire link_regs_pkg::word_t pwdata,
  input wire link_regs_pkg::strb_t pstrb,
  output link_regs_pkg::word_t prdata,
  output logic pready,
  output logic pslverr,
  // register side
  link_bus_if.port bus
);
  import link_regs_pkg::*;

  logic setupPhase;
  word_t prdata_r;
  logic pready_r;
  logic pslverr_r;

  // address and data pass straight on; the master holds them through the transfer
  assign setupPhase = psel & ~penable;
  assign bus.addr = paddr;
  assign bus.wdata = pwdata;
  assign bus.strb = pstrb;
  assign bus.wrStb = psel & penable & pwrite & pready_r & bus.hit;

  // answer in the first access cycle; read data is caught at setup so prdata is a flop
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end
    else
    begin
      pready_r <= setupPhase;
      pslverr_r <= setupPhase & ~bus.hit;
      if (setupPhase)
        prdata_r <= (pwrite | ~bus.hit) ? 32'h0 : bus.rdData;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
endmodule
`default_nettype wire

//--- design/fts_burst_seq.sv
// fast training sequence burst generator for leaving L0s
`include "link_regs_defines.svh"
`default_nettype none
module fts_burst_seq
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic l0sExitReq,
  input wire logic extendedSync,
  // transmitter strobes, one ordered set per cycle
  output logic txFts,
  output logic txSkp
);
  import link_regs_pkg::*;

  fts_state_e state_r, stateNxt;
  logic [12:0] ftsLeft_r, ftsLeftNxt;
  logic txFts_r, txSkp_r;
  logic [12:0] sentCnt_r;
  logic [12:0] expectCnt_r;

  // burst length is fixed at entry so a mid-burst change of the sync bit cannot cut it short
  always_comb
  begin
    stateNxt = state_r;
    ftsLeftNxt = ftsLeft_r;
    case (state_r)
      FTS_IDLE:
        if (l0sExitReq)
        begin
          stateNxt = FTS_SEND;
          ftsLeftNxt = extendedSync ? `FTS_EXT_CNT : `FTS_STD_CNT;
        end
      FTS_SEND:
      begin
        ftsLeftNxt = ftsLeft_r - 13'h1;
        if (ftsLeft_r == 13'h1)
          stateNxt = SKP_SEND;
      end
      SKP_SEND: stateNxt = FTS_IDLE;
      default: stateNxt = FTS_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= FTS_IDLE;
      ftsLeft_r <= 13'h0;
      txFts_r <= 1'b0;
      txSkp_r <= 1'b0;
    end
    else
    begin
      state_r <= stateNxt;
      ftsLeft_r <= ftsLeftNxt;
      txFts_r <= stateNxt == FTS_SEND;
      txSkp_r <= stateNxt == SKP_SEND;
    end
  end

  assign txFts = txFts_r;
  assign txSkp = txSkp_r;

  // checker helpers: count the strobes of the running burst
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sentCnt_r <= 13'h0;
      expectCnt_r <= 13'h0;
    end
    else if (state_r == FTS_IDLE && l0sExitReq)
    begin
      sentCnt_r <= 13'h0;
      expectCnt_r <= extendedSync ? `FTS_EXT_CNT : `FTS_STD_CNT;
    end
    else if (txFts_r)
      sentCnt_r <= sentCnt_r + 13'h1;
  end

  AST_BURST_LEN: assert property (@(posedge clk) disable iff (!rst_b) // R18
    txSkp_r |-> sentCnt_r == expectCnt_r)
    else $error("fts burst length wrong at skp");
  AST_ONE_SKP: assert property (@(posedge clk) disable iff (!rst_b) // R18
    txSkp_r |=> !txSkp_r && !txFts_r)
    else $error("more than one skp after fts burst");
endmodule
`default_nettype wire

//--- design/pcie_link_cap_ctl_regs.sv
// link capabilities and link control registers of one switch port
//
// Overview of operation
// R1 - max_link_speed always reads the fixed code 0x1, 2.5 Gbps.
// R2 - max_link_width sits in bits 9:4, resets to 0x8; codes 1, 2, 4, 8.
// R3 - a reserved max_link_width code makes the port train as x1.
// R4 - writing a narrower max_link_width while upstream_write_unlock is set forces a narrower negotiated link.
// R5 - low_power_support in bits 11:10 reads fixed 0x3, L0s and L1.
// R6 - l0s_exit_latency reads 0x5 with separate clocks, 0x3 with common clock.
// R7 - l1_exit_latency in bits 17:15 defaults to 0x2.
// R8 - the top byte reads this port's fixed number.
// R9 - aspm control in bits 1:0 resets 0x0: off, L0s, L1, both.
// R10 - aspm control starts disabled; an eeprom load may replace it.
// R11 - read completion boundary bit 3 always reads zero.
// R12 - on downstream ports link_disable holds the link down while set.
// R13 - on the upstream port link_disable is fixed at zero.
// R14 - writing one to link_retrain sends the LTSSM into Recovery.
// R15 - link_retrain always reads zero; it is a write-one trigger.
// R16 - upstream link_retrain works only while upstream_write_unlock is set.
// R17 - common_clock_cfg bit 6 resets zero and stores what software writes.
// R18 - extended_sync sends 4096 fts ordered sets then one skp in L0s.
// R19 - writes to read-only or reserved bits are dropped; reserved bits read zero.
// R20 - l0s_exit_latency follows common_clock_cfg whenever it changes.
`include "link_regs_defines.svh"
`default_nettype none
module pcie_link_cap_ctl_regs
#(
  // port number: 0 is the upstream port, 1 and 2 are downstream
  parameter logic [7:0] PORT_ID = 8'h00
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // apb register access
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire link_regs_pkg::addr_t paddr,
  input wire link_regs_pkg::word_t pwdata,
  input wire link_regs_pkg::strb_t pstrb,
  output link_regs_pkg::word_t prdata,
  output logic pready,
  output logic pslverr,
  // switch control
  input wire logic upstreamWriteUnlock,
  // serial eeprom initial load
  input wire logic eeLoad,
  input wire logic [1:0] eeAspmCtl,
  input wire logic [5:0] eeMaxLinkWidth,
  input wire logic [2:0] eeL1ExitLatency,
  // physical layer LTSSM
  input wire logic l0sExitReq,
  output logic [5:0] phyMaxLinkWidth,
  output logic [1:0] phyAspmCtl,
  output logic phyLinkDisable,
  output logic phyRetrain,
  output logic phyCommonClock,
  output logic txFts,
  output logic txSkp
);
  import link_regs_pkg::*;

  // the upstream port may not cut its own link: software there would lose the switch
  localparam logic IS_UP = PORT_ID == 8'h00;

  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------

  // legal widths pass, anything reserved falls back to a single lane
  function automatic logic [5:0] resolveWidth(input logic [5:0] code);
    logic legal;
    legal = (code == `WIDTH_X1) | (code == `WIDTH_X2) | (code == `WIDTH_X4) | (code == `WIDTH_X8);
    resolveWidth = legal ? code : `WIDTH_X1;
  endfunction

  // a field is written only when every byte lane it touches is enabled
  function automatic logic lanesOn(input strb_t strb, input strb_t need);
    lanesOn = (strb & need) == need;
  endfunction

  // --------------------------------------------------------------
  // bus front end
  // --------------------------------------------------------------

  link_bus_if bus ();

  link_apb_port uApb
  (
    .clk(clk),
    .rst_b(rst_b),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .bus(bus)
  );

  // --------------------------------------------------------------
  // address decode and write strobes
  // --------------------------------------------------------------

  logic capSel;
  logic ctlSel;
  logic capWrAllow;
  logic widthWr;
  logic l1Wr;
  logic ctlWr;
  logic retrainAllow;
  logic retrainHit;

  // lockable capability fields accept bus writes only while unlocked
  assign capSel = bus.addr == `LCAP_OFFSET;
  assign ctlSel = bus.addr == `LCTL_OFFSET;
  assign bus.hit = capSel | ctlSel;
  assign capWrAllow = bus.wrStb & capSel & upstreamWriteUnlock;
  // R4 width override
  assign widthWr = capWrAllow & lanesOn(bus.strb, 4'h3);
  assign l1Wr = capWrAllow & lanesOn(bus.strb, 4'h6);
  assign ctlWr = bus.wrStb & ctlSel & bus.strb[0];
  // R16 upstream retrain lock
  assign retrainAllow = ~IS_UP | upstreamWriteUnlock;
  // R14 retrain trigger
  assign retrainHit = ctlWr & bus.wdata[`LINK_RETRAIN_BIT] & retrainAllow;

  // --------------------------------------------------------------
  // stored fields
  // --------------------------------------------------------------

  logic [5:0] maxWidth_r, maxWidth_nxt;
  logic [2:0] l1Lat_r, l1Lat_nxt;
  logic [1:0] aspm_r, aspm_nxt;
  logic linkDis_r, linkDis_nxt;
  logic common_clock_cfg_r, common_clock_cfg_nxt;
  logic extended_sync_r, extended_sync_nxt;
  logic [5:0] phyWidth_r;
  logic retrain_r;

  // eeprom load takes priority: it runs before software can reach the port
  // R4 width override
  assign maxWidth_nxt = eeLoad ? eeMaxLinkWidth : widthWr ? bus.wdata[`WID_MSB:`WID_LSB] : maxWidth_r;
  assign l1Lat_nxt = eeLoad ? eeL1ExitLatency : l1Wr ? bus.wdata[`L1_MSB:`L1_LSB] : l1Lat_r;
  // R10 eeprom initial value
  assign aspm_nxt = eeLoad ? eeAspmCtl : ctlWr ? bus.wdata[`ASPM_MSB:0] : aspm_r;
  // R13 upstream disable tied off
  assign linkDis_nxt = IS_UP ? 1'b0 : ctlWr ? bus.wdata[`LINK_DISABLE_BIT] : linkDis_r;
  // R17 common clock stored
  assign common_clock_cfg_nxt = ctlWr ? bus.wdata[`COMMON_CLOCK_CFG_BIT] : common_clock_cfg_r;
  assign extended_sync_nxt = ctlWr ? bus.wdata[`EXTENDED_SYNC_BIT] : extended_sync_r;

  // R2 width reset value
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      maxWidth_r <= `WIDTH_RST;
      l1Lat_r <= `L1_RST;
      aspm_r <= `ASPM_RST;
      linkDis_r <= 1'b0;
      common_clock_cfg_r <= 1'b0;
      extended_sync_r <= 1'b0;
    end
    else
    begin
      maxWidth_r <= maxWidth_nxt;
      l1Lat_r <= l1Lat_nxt;
      aspm_r <= aspm_nxt;
      linkDis_r <= linkDis_nxt;
      common_clock_cfg_r <= common_clock_cfg_nxt;
      extended_sync_r <= extended_sync_nxt;
    end
  end

  // --------------------------------------------------------------
  // physical layer controls
  // --------------------------------------------------------------

  // R3 reserved width trains x1
  // retrain is a one-cycle pulse, never stored as readable state
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phyWidth_r <= `WIDTH_X1;
      retrain_r <= 1'b0;
    end
    else
    begin
      phyWidth_r <= resolveWidth(maxWidth_r);
      retrain_r <= retrainHit;
    end
  end

  // R12 disable holds link down
  assign phyLinkDisable = linkDis_r;
  assign phyMaxLinkWidth = phyWidth_r;
  assign phyAspmCtl = aspm_r;
  assign phyRetrain = retrain_r;
  assign phyCommonClock = common_clock_cfg_r;

  // R18 extended sync burst
  fts_burst_seq uFts
  (
    .clk(clk),
    .rst_b(rst_b),
    .l0sExitReq(l0sExitReq),
    .extendedSync(extended_sync_r),
    .txFts(txFts),
    .txSkp(txSkp)
  );

  // --------------------------------------------------------------
  // read words
  // --------------------------------------------------------------

  logic [2:0] l0sLat;
  word_t capWord;
  word_t ctlWord;

  // R20 latency tracks clocking
  // R6 l0s latency codes
  assign l0sLat = common_clock_cfg_r ? `L0S_COMMON : `L0S_SEPARATE;

  // R1 fixed speed
  // R5 fixed low power support
  // R7 l1 latency field
  // R8 port number
  // R19 reserved bits zero
  assign capWord = {PORT_ID, 6'h00, l1Lat_r, l0sLat, `LOW_POWER_CODE, maxWidth_r, `MAX_SPEED_CODE};

  // R11 boundary bit zero
  // R15 retrain reads zero
  assign ctlWord = {24'h000000, extended_sync_r, common_clock_cfg_r, 1'b0, linkDis_r, 1'b0, 1'b0, aspm_r};

  // R9 aspm field readback
  assign bus.rdData = capSel ? capWord : ctlSel ? ctlWord : 32'h0;

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------

  // every check below runs on the one core clock and sleeps during reset
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // port-level views of each completed transfer
  logic capRead;
  logic ctlRead;
  logic ctlWrite;
  logic capWrite;
  logic badAccess;

  // completed reads and writes, seen at the ports
  assign capRead = psel & penable & pready & ~pwrite & (paddr == `LCAP_OFFSET);
  assign ctlRead = psel & penable & pready & ~pwrite & (paddr == `LCTL_OFFSET);
  assign ctlWrite = psel & penable & pready & pwrite & (paddr == `LCTL_OFFSET) & pstrb[0];
  assign capWrite = psel & penable & pready & pwrite & (paddr == `LCAP_OFFSET);
  assign badAccess = psel & penable & pready & (paddr != `LCAP_OFFSET) & (paddr != `LCTL_OFFSET);

  AST_SPEED_FIXED: assert property (capRead |-> prdata[`SPD_MSB:0] == `MAX_SPEED_CODE) // R1
    else $error("max link speed not 0x1");
  AST_WIDTH_RESET: assert property ($rose(rst_b) |-> maxWidth_r == `WIDTH_RST) // R2
    else $error("max link width reset not 0x8");
  AST_WIDTH_X1: assert property ( // R3
    (resolveWidth(maxWidth_r) != maxWidth_r) |=> phyMaxLinkWidth == `WIDTH_X1)
    else $error("reserved width not forced to x1");
  AST_WIDTH_OVR: assert property ( // R4
    (psel && penable && pready && pwrite && paddr == `LCAP_OFFSET && upstreamWriteUnlock
     && pstrb[1:0] == 2'h3 && !eeLoad)
    |-> ##2 phyMaxLinkWidth == resolveWidth($past(pwdata[`WID_MSB:`WID_LSB], 2)))
    else $error("width override not applied");
  AST_LPS_FIXED: assert property (capRead |-> prdata[`LPS_MSB:`LPS_LSB] == `LOW_POWER_CODE) // R5
    else $error("low power support not 0x3");
  AST_L0S_LAT: assert property ( // R6
    capRead |-> prdata[`L0S_MSB:`L0S_LSB] == (phyCommonClock ? `L0S_COMMON : `L0S_SEPARATE))
    else $error("l0s latency does not match clocking");
  AST_L1_RESET: assert property ($rose(rst_b) |-> l1Lat_r == `L1_RST) // R7
    else $error("l1 latency reset not 0x2");
  AST_PORT_NUM: assert property (capRead |-> prdata[31:`PORT_LSB] == PORT_ID) // R8
    else $error("port number wrong");
  AST_ASPM_HOLD: assert property ((!ctlWrite && !eeLoad) |=> $stable(phyAspmCtl)) // R9
    else $error("aspm control changed without cause");
  AST_ASPM_EE: assert property (eeLoad |=> phyAspmCtl == $past(eeAspmCtl)) // R10
    else $error("eeprom aspm value not taken");
  AST_CTL_ZERO_BITS: assert property ( // R11
    ctlRead |-> prdata[`RCB_BIT] == 1'b0 && prdata[2] == 1'b0 && prdata[31:8] == 24'h000000)
    else $error("reserved or boundary bits of link control not zero");
  AST_LINK_DISABLE_DOWN: assert property ( // R12
    (ctlWrite && !IS_UP) |=> phyLinkDisable == $past(pwdata[`LINK_DISABLE_BIT]) ##1 1'b1)
    else $error("link disable not following write");
  AST_LINK_DISABLE_UP: assert property (IS_UP |-> !phyLinkDisable) // R13
    else $error("upstream link disabled");
  AST_RETRAIN: assert property ( // R14
    (ctlWrite && pwdata[`LINK_RETRAIN_BIT] && (!IS_UP || upstreamWriteUnlock)) |=> phyRetrain ##1 !phyRetrain)
    else $error("retrain pulse missing or too long");
  AST_RETRAIN_READ: assert property (ctlRead |-> prdata[`LINK_RETRAIN_BIT] == 1'b0) // R15
    else $error("retrain bit read as one");
  AST_RETRAIN_LOCK: assert property ( // R16
    (ctlWrite && IS_UP && !upstreamWriteUnlock) |=> !phyRetrain)
    else $error("locked upstream retrain acted");
  AST_COMMON_CLOCK_CFG_STORE: assert property (ctlWrite |=> phyCommonClock == $past(pwdata[`COMMON_CLOCK_CFG_BIT])) // R17
    else $error("common clock bit not stored");
  AST_RSVD_CAP: assert property (capRead |-> prdata[23:18] == 6'h00) // R19
    else $error("reserved capability bits not zero");
  AST_L0S_FOLLOW: assert property ( // R20
    ctlWrite |=> capWord[`L0S_MSB:`L0S_LSB] == ($past(pwdata[`COMMON_CLOCK_CFG_BIT]) ? `L0S_COMMON : `L0S_SEPARATE))
    else $error("l0s latency did not follow clocking change");

  // fields hold between writes; locked and unmapped accesses change nothing
  AST_LINK_DISABLE_HOLD: assert property (!ctlWrite |=> $stable(phyLinkDisable)) // R12
    else $error("link disable changed without a write");
  AST_COMMON_CLOCK_CFG_HOLD: assert property (!ctlWrite |=> $stable(phyCommonClock)) // R17
    else $error("common clock bit changed without a write");
  AST_EXTENDED_SYNC_STORE: assert property (ctlWrite |=> extended_sync_r == $past(pwdata[`EXTENDED_SYNC_BIT])) // R18
    else $error("extended sync bit not stored");
  AST_CAP_LOCKED: assert property ( // R19
    (capWrite && !upstreamWriteUnlock && !eeLoad) |=> $stable(maxWidth_r) && $stable(l1Lat_r))
    else $error("locked capability field written");
  AST_UNMAPPED: assert property ( // R19
    badAccess |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  // a stuck retrain would send the LTSSM back to Recovery over and over
  AST_RETRAIN_ONCE: assert property (phyRetrain |=> !phyRetrain) // R15
    else $error("retrain held longer than one cycle");
  AST_WIDTH_LEGAL: assert property ( // R3
    phyMaxLinkWidth inside {`WIDTH_X1, `WIDTH_X2, `WIDTH_X4, `WIDTH_X8})
    else $error("reserved width driven to the physical layer");

  COV_LINK_DOWN: cover property (phyLinkDisable);
  COV_WIDTH_NARROW: cover property (phyMaxLinkWidth == `WIDTH_X2);
  COV_RETRAIN: cover property (phyRetrain);
  COV_EXT_BURST: cover property (extended_sync_r && l0sExitReq);
  COV_BAD_ADDR: cover property (pslverr);
endmodule
`default_nettype wire

//--- bench/tb_pcie_link_cap_ctl_regs.sv
// self-checking testbench of the link capabilities and link control register pair
`include "link_regs_defines.svh"
`default_nettype none
module tb_pcie_link_cap_ctl_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import link_regs_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  // upstream port: exercises the fixed link disable and the locked retrain
  localparam logic [7:0] PORT_NUM = 8'h00;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  addr_t paddr = '0;
  word_t pwdata = '0, prdata;
  strb_t pstrb = '0;
  logic pready, pslverr;
  logic unlock = 1'b0, eeLoad = 1'b0, l0sExitReq = 1'b0;
  logic [1:0] eeAspm = '0, phyAspm;
  logic [5:0] eeWidth = '0, phyWidth;
  logic [2:0] eeL1 = '0;
  logic phyLdis, phyRetrain, phyCclk, txFts, txSkp;
  // bench copy of the stored fields
  logic [5:0] mWidth;
  logic [2:0] mL1;
  logic [1:0] mAspm;
  logic mCclk, mEsync, mLdisDn;
  // downstream port beside it: link disable and retrain without the unlock
  localparam logic [7:0] PORT_DN = 8'h01;
  word_t prdataDn, rdDn;
  logic phyLdisDn, phyRetrainDn;
  int errTotal = 0, totalChecks = 0, cycles = 0;

  pcie_link_cap_ctl_regs #(.PORT_ID(PORT_NUM)) uut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .upstreamWriteUnlock(unlock), .eeLoad(eeLoad), .eeAspmCtl(eeAspm),
    .eeMaxLinkWidth(eeWidth), .eeL1ExitLatency(eeL1), .l0sExitReq(l0sExitReq), .phyMaxLinkWidth(phyWidth),
    .phyAspmCtl(phyAspm), .phyLinkDisable(phyLdis), .phyRetrain(phyRetrain), .phyCommonClock(phyCclk),
    .txFts(txFts), .txSkp(txSkp));

  pcie_link_cap_ctl_regs #(.PORT_ID(PORT_DN)) uutDn (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdataDn), .pready(),
    .pslverr(), .upstreamWriteUnlock(unlock), .eeLoad(eeLoad), .eeAspmCtl(eeAspm),
    .eeMaxLinkWidth(eeWidth), .eeL1ExitLatency(eeL1), .l0sExitReq(l0sExitReq), .phyMaxLinkWidth(),
    .phyAspmCtl(), .phyLinkDisable(phyLdisDn), .phyRetrain(phyRetrainDn), .phyCommonClock(),
    .txFts(), .txSkp());

  // ----------------------------------------
  // clock, timeout and report
  // ----------------------------------------
  always #10 clk = ~clk;

  // the longest burst is 4096 cycles, so the ceiling leaves ample margin
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errTotal++;
      tallyAndFinish();
    end
  end

  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input word_t seen, input word_t exp);
    totalChecks++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // ----------------------------------------
  // expectations
  // ----------------------------------------
  function automatic word_t capExp();
    capExp = {PORT_NUM, 6'h00, mL1, mCclk ? `L0S_COMMON : `L0S_SEPARATE, `LOW_POWER_CODE, mWidth, `MAX_SPEED_CODE};
  endfunction

  // retrain, read boundary, reserved bit 2 and link disable read zero on this port
  function automatic word_t ctlExp();
    ctlExp = {24'h000000, mEsync, mCclk, 4'h0, mAspm};
  endfunction

  function automatic logic [5:0] widthExp();
    widthExp = (mWidth inside {`WIDTH_X1, `WIDTH_X2, `WIDTH_X4, `WIDTH_X8}) ? mWidth : `WIDTH_X1;
  endfunction

  // ----------------------------------------
  // drivers
  // ----------------------------------------
  // one apb transfer; the request stands until pready is seen high
  task automatic apb(input logic wr, input addr_t a, input word_t d, input strb_t s, output word_t rd,
    output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1);
    rd = prdata;
    rdDn = prdataDn;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk("pready latency", n, 32'h1);
  endtask

  // a second request in mid-burst must not stretch or restart it
  task automatic ftsRun(input int expLen);
    int n;
    @(posedge clk);
    l0sExitReq <= 1'b1;
    @(posedge clk);
    l0sExitReq <= 1'b0;
    n = 0;
    while (txFts !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (txFts === 1'b1 && n < 5000)
    begin
      l0sExitReq <= (n == 10);
      @(posedge clk);
      n++;
    end
    l0sExitReq <= 1'b0;
    chk("fts count", n, expLen);
    chk("skp pulse", txSkp, 1'b1);
    @(posedge clk);
    chk("skp end", {txSkp, txFts}, 2'b00);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    word_t d, rd;
    logic err, u;
    strb_t s;
    static logic [5:0] corner [8] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h03, 6'h00, 6'h10, 6'h3f};
    void'($urandom(61));
    mWidth = `WIDTH_RST;
    mL1 = `L1_RST;
    mAspm = `ASPM_RST;
    mCclk = 1'b0;
    mEsync = 1'b0;
    mLdisDn = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, `LCAP_OFFSET, '0, '0, rd, err);
    chk("cap reset", rd, capExp());
    chk("width reset", phyWidth, mWidth);
    apb(1'b0, `LCTL_OFFSET, '0, '0, rd, err);
    chk("ctl reset", rd, ctlExp());
    // random control writes, lanes and unlock
    repeat (30)
    begin
      d = $urandom();
      s = 4'($urandom());
      u = 1'($urandom());
      unlock <= u;
      apb(1'b1, `LCTL_OFFSET, d, s, rd, err);
      #1;
      chk("retrain pulse", phyRetrain, s[0] & d[5] & u);
      chk("dn retrain pulse", phyRetrainDn, s[0] & d[5]);
      if (s[0])
      begin
        mAspm = d[1:0];
        mCclk = d[6];
        mEsync = d[7];
        mLdisDn = d[4];
      end
      chk("aspm out", phyAspm, mAspm);
      chk("common_clock_cfg out", phyCclk, mCclk);
      chk("link_disable out", phyLdis, 1'b0);
      chk("dn link_disable out", phyLdisDn, mLdisDn);
      apb(1'b0, `LCTL_OFFSET, '0, '0, rd, err);
      chk("ctl read", rd, ctlExp());
      chk("dn ctl read", rdDn, ctlExp() | {27'h0000000, mLdisDn, 4'h0});
      chk("retrain idle", phyRetrain, 1'b0);
      apb(1'b0, `LCAP_OFFSET, '0, '0, rd, err);
      chk("cap latency", rd, capExp());
    end
    // capabilities writes: every width code class first, then random
    for (int i = 0; i < 24; i++)
    begin
      d = $urandom();
      s = (i < 8) ? 4'hf : 4'($urandom());
      u = (i < 8) ? 1'b1 : 1'($urandom());
      if (i < 8)
        d[9:4] = corner[i];
      unlock <= u;
      apb(1'b1, `LCAP_OFFSET, d, s, rd, err);
      if (u && s[1:0] == 2'b11)
        mWidth = d[9:4];
      if (u && s[2:1] == 2'b11)
        mL1 = d[17:15];
      repeat (2) @(posedge clk);
      #1;
      chk("phy width", phyWidth, widthExp());
      apb(1'b0, `LCAP_OFFSET, '0, '0, rd, err);
      chk("cap read", rd, capExp());
      chk("dn cap read", rdDn, {PORT_DN, 24'h000000} | (capExp() & 32'h00ffffff));
    end
    // unmapped places answer with an error and change nothing
    foreach (corner[i])
    begin
      d = {20'h00000, 12'(12'h054 + 12'(i) * 12'h004)};
      apb(1'b1, d[11:0], 32'hffffffff, 4'hf, rd, err);
      chk("unmapped write", err, 1'b1);
      apb(1'b0, d[11:0], '0, '0, rd, err);
      chk("unmapped read", {err, rd[30:0]}, 32'h80000000);
    end
    apb(1'b0, `LCTL_OFFSET, '0, '0, rd, err);
    chk("ctl intact", rd, ctlExp());
    // eeprom initial load replaces aspm control, max link width and l1 exit latency
    @(posedge clk);
    eeLoad <= 1'b1;
    eeAspm <= 2'($urandom());
    eeWidth <= 6'($urandom());
    eeL1 <= 3'($urandom());
    @(posedge clk);
    eeLoad <= 1'b0;
    mAspm = eeAspm;
    mWidth = eeWidth;
    mL1 = eeL1;
    repeat (2) @(posedge clk);
    #1;
    chk("ee aspm", phyAspm, mAspm);
    chk("ee width", phyWidth, widthExp());
    apb(1'b0, `LCTL_OFFSET, '0, '0, rd, err);
    chk("ee ctl", rd, ctlExp());
    apb(1'b0, `LCAP_OFFSET, '0, '0, rd, err);
    chk("ee cap", rd, capExp());
    // fts bursts with extended sync off, then on
    apb(1'b1, `LCTL_OFFSET, 32'h00000000, 4'hf, rd, err);
    ftsRun(`FTS_STD_CNT);
    apb(1'b1, `LCTL_OFFSET, 32'h00000080, 4'hf, rd, err);
    ftsRun(`FTS_EXT_CNT);
    tallyAndFinish();
  end
endmodule
`default_nettype wire
